//--- rtl/sdieq_pkg.sv
// Shared constants, types and decode functions of the equalizer control block.
package sdieq_pkg;

  typedef enum logic [1:0] {
    LVL_L = 2'h0,
    LVL_R = 2'h1,
    LVL_F = 2'h2,
    LVL_H = 2'h3
  } sdieq_level_t;

  typedef enum logic [1:0] {
    CST_SAVE  = 2'h0,
    CST_ADAPT = 2'h1,
    CST_LOCK  = 2'h2
  } sdieq_cstate_t;

  localparam logic [7:0] OFS_MUTE_LIMIT = 8'h03;
  localparam logic [7:0] OFS_MODE_CTRL = 8'h04;
  localparam logic [7:0] OFS_PATH_CTRL = 8'h05;
  localparam logic [7:0] OFS_CABLE_LEN = 8'h25;
  localparam logic [7:0] OFS_A_SWING = 8'h30;
  localparam logic [7:0] OFS_A_DEEMPH = 8'h31;
  localparam logic [7:0] OFS_B_SWING = 8'h32;
  localparam logic [7:0] OFS_B_DEEMPH = 8'h33;

  localparam int BIT_SWING_OVR = 5;
  localparam int BIT_DEEMPH_OVR = 6;
  localparam int BIT_SPLITTER = 0;
  localparam int BIT_ROUTE_OVR = 0;
  localparam int BIT_ROUTE_BOTH = 1;
  localparam int BIT_FUNC_OVR = 2;
  localparam int BIT_FUNC_BYPASS = 3;

  localparam logic [5:0] RST_MUTE_LIMIT = 6'h37;
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [5:0] CABLE_LEN_MAX = 6'h37;

  localparam logic [2:0] DRV_LVL_H = 3'h0;
  localparam logic [2:0] DRV_LVL_F = 3'h2;
  localparam logic [2:0] DRV_LVL_R = 3'h3;
  localparam logic [2:0] DRV_LVL_L = 3'h5;

  // Comparator code of an open pin, used to preset the strap synchronisers.
  localparam logic [2:0] CMP_OPEN_PIN = 3'h3;

  // Comparators sit at 0.2, 0.5 and 0.8 of the I/O supply, bit 0 lowest.
  function automatic sdieq_level_t sdieq_classify(input logic [2:0] cmp);
    case (cmp)
      3'h0: sdieq_classify = LVL_L;
      3'h1: sdieq_classify = LVL_R;
      3'h7: sdieq_classify = LVL_H;
      // An open pin biases to two thirds of the supply, which is F.
      default: sdieq_classify = LVL_F;
    endcase
  endfunction : sdieq_classify

  function automatic logic [2:0] sdieq_drive_map(input sdieq_level_t lvl);
    case (lvl)
      LVL_H: sdieq_drive_map = DRV_LVL_H;
      LVL_F: sdieq_drive_map = DRV_LVL_F;
      LVL_R: sdieq_drive_map = DRV_LVL_R;
      default: sdieq_drive_map = DRV_LVL_L;
    endcase
  endfunction : sdieq_drive_map

endpackage : sdieq_pkg

//--- rtl/sdieq_carrier_if.sv
// Carrier detect signals shared between the top and the carrier state machine.
interface sdieq_carrier_if;
  logic amp_raw;
  logic adapt_done_raw;
  logic amp_sync;
  logic carrier_missing_n;
  logic adapt_run;
  logic eq_power_down;
  logic power_save;
  sdieq_pkg::sdieq_cstate_t state;
  modport fsm (input amp_raw, adapt_done_raw, output amp_sync, carrier_missing_n,
    adapt_run, eq_power_down, power_save, state);
  modport top (output amp_raw, adapt_done_raw, input amp_sync, carrier_missing_n,
    adapt_run, eq_power_down, power_save, state);
endinterface : sdieq_carrier_if

//--- rtl/sdieq_strap.sv
// Four-level strap pin classifier with input synchroniser.
module sdieq_strap
  import sdieq_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic [2:0] cmp_i,
  output sdieq_level_t level_o
);
  logic [2:0] cmp_meta;
  logic [2:0] cmp_sync;

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      // Presetting to the open-pin code keeps a false low level out after reset.
      cmp_meta <= CMP_OPEN_PIN;
      cmp_sync <= CMP_OPEN_PIN;
      level_o <= LVL_F;
    end else begin
      cmp_meta <= cmp_i;
      cmp_sync <= cmp_meta;
      level_o <= sdieq_classify(cmp_sync);
    end
  end

  a_level_class: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (cmp_sync == 3'h7) |=> (level_o == LVL_H))
    else $error("Strap above all thresholds not decoded as high.");
endmodule : sdieq_strap

//--- rtl/sdieq_carrier.sv
// Carrier detect, adaptation and power-save sequencing.
module sdieq_carrier
  import sdieq_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rstn_i,
  sdieq_carrier_if.fsm cif
);
  logic amp_meta;
  logic done_meta;
  logic done_sync;
  sdieq_cstate_t next_state;

  always_comb begin
    next_state = cif.state;
    case (cif.state)
      CST_SAVE: begin
        if (cif.amp_sync) begin
          next_state = CST_ADAPT;
        end
      end
      CST_ADAPT: begin
        if (!cif.amp_sync) begin
          next_state = CST_SAVE;
        end else if (done_sync) begin
          next_state = CST_LOCK;
        end
      end
      CST_LOCK: begin
        if (!cif.amp_sync) begin
          next_state = CST_SAVE;
        end
      end
      default: next_state = CST_SAVE;
    endcase
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      amp_meta <= 1'b0;
      cif.amp_sync <= 1'b0;
      done_meta <= 1'b0;
      done_sync <= 1'b0;
      cif.state <= CST_SAVE;
      cif.carrier_missing_n <= 1'b1;
      cif.adapt_run <= 1'b0;
      cif.eq_power_down <= 1'b1;
      cif.power_save <= 1'b1;
    end else begin
      amp_meta <= cif.amp_raw;
      cif.amp_sync <= amp_meta;
      done_meta <= cif.adapt_done_raw;
      done_sync <= done_meta;
      cif.state <= next_state;
      cif.carrier_missing_n <= (next_state != CST_LOCK);
      cif.adapt_run <= (next_state == CST_ADAPT);
      cif.eq_power_down <= (next_state == CST_SAVE);
      cif.power_save <= (next_state == CST_SAVE);
    end
  end
endmodule : sdieq_carrier

//--- rtl/sdieq_ctrl.sv
// Top of the equalizer configuration and status control block.
// What this block does
// - Classify each strap into four levels.
// - Open strap pin decodes as F.
// - Carrier present: adapt, then flag carrier.
// - Carrier lost: power down, flag missing.
// - Power save follows carrier absence automatically.
// - Splitter mode enabled only by register.
// - Route strap: H both drivers, F driver A.
// - Register override replaces route strap.
// - Function strap: H bypass, F equalized.
// - Register override replaces function strap.
// - Drive strap maps to levels 0,2,3,5.
// - Per-driver swing override at bit 5.
// - Per-driver de-emphasis override at bit 6.
// - Report cable length estimate, 0 to 55.
// - Mute drivers when length exceeds threshold.
module sdieq_ctrl
  import sdieq_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic [2:0] route_cmp_i,
  input wire logic [2:0] func_cmp_i,
  input wire logic [2:0] drive_cmp_i,
  input wire logic amp_above_i,
  input wire logic adapt_done_i,
  input wire logic [5:0] cable_len_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  output logic carrier_missing_n_o,
  output logic adapt_run_o,
  output logic eq_power_down_o,
  output logic power_save_o,
  output logic splitter_mode_o,
  output logic driver_a_en_o,
  output logic driver_b_en_o,
  output logic bypass_o,
  output logic mute_o,
  output logic [2:0] swing_a_o,
  output logic [2:0] deemph_a_o,
  output logic [2:0] swing_b_o,
  output logic [2:0] deemph_b_o
);

  sdieq_level_t route_lvl;
  sdieq_level_t func_lvl;
  sdieq_level_t drive_lvl;

  sdieq_strap u_route_strap (
    .mclk_i (mclk_i),
    .rstn_i (rstn_i),
    .cmp_i (route_cmp_i),
    .level_o (route_lvl)
  );

  sdieq_strap u_func_strap (
    .mclk_i (mclk_i),
    .rstn_i (rstn_i),
    .cmp_i (func_cmp_i),
    .level_o (func_lvl)
  );

  sdieq_strap u_drive_strap (
    .mclk_i (mclk_i),
    .rstn_i (rstn_i),
    .cmp_i (drive_cmp_i),
    .level_o (drive_lvl)
  );

  sdieq_carrier_if cif ();

  assign cif.amp_raw = amp_above_i;
  assign cif.adapt_done_raw = adapt_done_i;

  sdieq_carrier u_carrier (
    .mclk_i (mclk_i),
    .rstn_i (rstn_i),
    .cif (cif)
  );

  assign carrier_missing_n_o = cif.carrier_missing_n;
  assign adapt_run_o = cif.adapt_run;
  assign eq_power_down_o = cif.eq_power_down;
  assign power_save_o = cif.power_save;

  // Register file. Only defined bits are stored; the rest read as zero.
  logic [5:0] mute_limit;
  logic [7:0] mode_ctrl;
  logic [7:0] path_ctrl;
  logic [7:0] a_swing;
  logic [7:0] a_deemph;
  logic [7:0] b_swing;
  logic [7:0] b_deemph;

  wire logic wr_mute = reg_wr_i && (reg_addr_i == OFS_MUTE_LIMIT);
  wire logic wr_mode = reg_wr_i && (reg_addr_i == OFS_MODE_CTRL);
  wire logic wr_path = reg_wr_i && (reg_addr_i == OFS_PATH_CTRL);
  wire logic wr_a_sw = reg_wr_i && (reg_addr_i == OFS_A_SWING);
  wire logic wr_a_de = reg_wr_i && (reg_addr_i == OFS_A_DEEMPH);
  wire logic wr_b_sw = reg_wr_i && (reg_addr_i == OFS_B_SWING);
  wire logic wr_b_de = reg_wr_i && (reg_addr_i == OFS_B_DEEMPH);

  wire logic [7:0] swing_mask = 8'h27;
  wire logic [7:0] deemph_mask = 8'h47;
  wire logic [7:0] mode_mask = 8'h01;
  wire logic [7:0] path_mask = 8'h0F;

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mute_limit <= RST_MUTE_LIMIT;
      mode_ctrl <= RST_CTRL;
      path_ctrl <= RST_CTRL;
      a_swing <= RST_CTRL;
      a_deemph <= RST_CTRL;
      b_swing <= RST_CTRL;
      b_deemph <= RST_CTRL;
    end else begin
      if (wr_mute) begin
        mute_limit <= reg_wdata_i[5:0];
      end
      if (wr_mode) begin
        mode_ctrl <= reg_wdata_i & mode_mask;
      end
      if (wr_path) begin
        path_ctrl <= reg_wdata_i & path_mask;
      end
      if (wr_a_sw) begin
        a_swing <= reg_wdata_i & swing_mask;
      end
      if (wr_a_de) begin
        a_deemph <= reg_wdata_i & deemph_mask;
      end
      if (wr_b_sw) begin
        b_swing <= reg_wdata_i & swing_mask;
      end
      if (wr_b_de) begin
        b_deemph <= reg_wdata_i & deemph_mask;
      end
    end
  end

  // The analog length estimate is synchronised and held within its range.
  // A new length is taken only once it reads the same on two edges, so a word
  // caught in the middle of a change never reaches the estimate.
  logic [5:0] len_meta;
  logic [5:0] len_sync;
  logic [5:0] len_prev;
  logic [5:0] cable_length_estimate;

  wire logic len_steady = (len_sync == len_prev);

  wire logic [5:0] next_estimate =
    (len_sync > CABLE_LEN_MAX) ? CABLE_LEN_MAX : len_sync;

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      len_meta <= 6'h00;
      len_sync <= 6'h00;
      len_prev <= 6'h00;
      cable_length_estimate <= 6'h00;
    end else begin
      len_meta <= cable_len_i;
      len_sync <= len_meta;
      len_prev <= len_sync;
      if (len_steady) begin
        cable_length_estimate <= next_estimate;
      end
    end
  end

  // Read data answers one cycle after the read strobe.
  logic [7:0] read_mux;

  always_comb begin
    case (reg_addr_i)
      OFS_MUTE_LIMIT: read_mux = {2'h0, mute_limit};
      OFS_MODE_CTRL: read_mux = mode_ctrl;
      OFS_PATH_CTRL: read_mux = path_ctrl;
      OFS_CABLE_LEN: read_mux = {2'h0, cable_length_estimate};
      OFS_A_SWING: read_mux = a_swing;
      OFS_A_DEEMPH: read_mux = a_deemph;
      OFS_B_SWING: read_mux = b_swing;
      OFS_B_DEEMPH: read_mux = b_deemph;
      default: read_mux = 8'h00;
    endcase
  end

  // Selection between strap decode and register override.
  wire logic route_ovr = path_ctrl[BIT_ROUTE_OVR];
  wire logic func_ovr = path_ctrl[BIT_FUNC_OVR];
  wire logic [2:0] strap_drive = sdieq_drive_map(drive_lvl);

  // Reserved route levels fall back to the single-driver path.
  wire logic next_b_en = route_ovr ? path_ctrl[BIT_ROUTE_BOTH]
                                   : (route_lvl == LVL_H);
  // Reserved function levels fall back to equalized data.
  wire logic next_bypass = func_ovr ? path_ctrl[BIT_FUNC_BYPASS]
                                    : (func_lvl == LVL_H);
  wire logic [2:0] next_swing_a =
    a_swing[BIT_SWING_OVR] ? a_swing[2:0] : strap_drive;
  wire logic [2:0] next_swing_b =
    b_swing[BIT_SWING_OVR] ? b_swing[2:0] : strap_drive;
  wire logic [2:0] next_deemph_a =
    a_deemph[BIT_DEEMPH_OVR] ? a_deemph[2:0] : strap_drive;
  wire logic [2:0] next_deemph_b =
    b_deemph[BIT_DEEMPH_OVR] ? b_deemph[2:0] : strap_drive;
  wire logic next_mute = (cable_length_estimate > mute_limit);

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      reg_rdata_o <= 8'h00;
      splitter_mode_o <= 1'b0;
      driver_a_en_o <= 1'b0;
      driver_b_en_o <= 1'b0;
      bypass_o <= 1'b0;
      mute_o <= 1'b0;
      swing_a_o <= 3'h0;
      swing_b_o <= 3'h0;
      deemph_a_o <= 3'h0;
      deemph_b_o <= 3'h0;
    end else begin
      if (reg_rd_i) begin
        reg_rdata_o <= read_mux;
      end
      splitter_mode_o <= mode_ctrl[BIT_SPLITTER];
      driver_a_en_o <= 1'b1;
      driver_b_en_o <= next_b_en;
      bypass_o <= next_bypass;
      mute_o <= next_mute;
      swing_a_o <= next_swing_a;
      swing_b_o <= next_swing_b;
      deemph_a_o <= next_deemph_a;
      deemph_b_o <= next_deemph_b;
    end
  end

  a_carrier_after_adapt: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    $fell(carrier_missing_n_o) |-> $past(cif.state) == CST_ADAPT && cif.state == CST_LOCK)
    else $error("Carrier flagged present without completed adaptation.");

  a_carrier_loss: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (cif.state != CST_SAVE && !cif.amp_sync)
    |=> carrier_missing_n_o && eq_power_down_o && cif.state == CST_SAVE)
    else $error("Carrier loss did not power down and flag missing.");

  a_power_save_tie: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    power_save_o == (cif.state == CST_SAVE) && (power_save_o -> carrier_missing_n_o))
    else $error("Power save does not follow carrier absence.");

  a_save_exit: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (cif.state == CST_SAVE && cif.amp_sync) |=> !power_save_o && adapt_run_o)
    else $error("Power save not left when signal returned.");

  a_splitter_write: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    wr_mode |=> ##1 splitter_mode_o == $past(reg_wdata_i[BIT_SPLITTER], 2))
    else $error("Splitter mode does not follow its register write.");

  a_route_strap: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    $past(rstn_i) && !route_ovr
    |=> driver_a_en_o && driver_b_en_o == ($past(route_lvl) == LVL_H))
    else $error("Driver routing does not follow route strap.");

  a_route_override: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    route_ovr |=> driver_b_en_o == $past(path_ctrl[BIT_ROUTE_BOTH]))
    else $error("Route override bit not applied.");

  a_func_strap: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (!func_ovr && func_lvl == LVL_H) |=> bypass_o)
    else $error("Function strap high did not select bypass.");

  a_func_override: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    func_ovr |=> bypass_o == $past(path_ctrl[BIT_FUNC_BYPASS]))
    else $error("Function override bit not applied.");

  a_drive_strap: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (!a_swing[BIT_SWING_OVR] && !b_deemph[BIT_DEEMPH_OVR] && drive_lvl == LVL_L)
    |=> swing_a_o == 3'h5 && deemph_b_o == 3'h5)
    else $error("Drive strap low did not give level five.");

  a_swing_override: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    wr_b_sw && reg_wdata_i[BIT_SWING_OVR] |=> ##1 swing_b_o == $past(reg_wdata_i[2:0], 2))
    else $error("Driver B swing override not applied.");

  a_deemph_override: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    wr_a_de && reg_wdata_i[BIT_DEEMPH_OVR] |=> ##1 deemph_a_o == $past(reg_wdata_i[2:0], 2))
    else $error("Driver A de-emphasis override not applied.");

  a_length_range: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    cable_length_estimate <= CABLE_LEN_MAX)
    else $error("Cable length estimate out of range.");

  a_mute_set: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (cable_length_estimate > mute_limit) |=> mute_o)
    else $error("Drivers not muted beyond threshold.");

  a_mute_release: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (cable_length_estimate <= mute_limit) |=> !mute_o)
    else $error("Drivers not unmuted within threshold.");

  a_strap_default: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    $past(rstn_i) && !a_deemph[BIT_DEEMPH_OVR]
    |=> deemph_a_o == sdieq_drive_map($past(drive_lvl)))
    else $error("Cleared override did not return to strap setting.");

endmodule : sdieq_ctrl

//--- testbench/sdieq_front_model.sv
// Behavioural model of the strap pins, the coax source and the analog equalizer front end.
module sdieq_front_model #(
  parameter int ADAPT_CYC = 20
) (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic carrier_on_i,
  input wire logic [5:0] length_i,
  input wire logic [6:0] route_pct_i,
  input wire logic [6:0] func_pct_i,
  input wire logic [6:0] drive_pct_i,
  output logic [2:0] route_cmp_o,
  output logic [2:0] func_cmp_o,
  output logic [2:0] drive_cmp_o,
  output logic amp_above_o,
  output logic adapt_done_o,
  output logic [5:0] cable_len_o
);
  timeunit 1ns;
  timeprecision 100ps;
  int unsigned adapt_cnt;

  // Pin voltage in percent of the I/O supply against the three comparison points.
  function automatic logic [2:0] pin_cmp(input logic [6:0] pct);
    return {pct > 7'h50, pct > 7'h32, pct > 7'h14};
  endfunction : pin_cmp

  assign route_cmp_o = pin_cmp(route_pct_i);
  assign func_cmp_o = pin_cmp(func_pct_i);
  assign drive_cmp_o = pin_cmp(drive_pct_i);
  assign amp_above_o = carrier_on_i;
  assign cable_len_o = length_i;
  // Adaptation only finishes a fixed time after the carrier appears.
  assign adapt_done_o = carrier_on_i && (adapt_cnt == ADAPT_CYC);

  always @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i || !carrier_on_i) begin
      adapt_cnt <= 0;
    end else if (adapt_cnt < ADAPT_CYC) begin
      adapt_cnt <= adapt_cnt + 1;
    end
  end
endmodule : sdieq_front_model

//--- testbench/sdieq_ctrl_test.sv
// Self-checking testbench of the equalizer configuration and status control block.
module sdieq_ctrl_test
  import sdieq_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic carrier_on = 1'b0;
  logic [5:0] length = 6'h00;
  // An open strap pin sits at two thirds of the supply.
  logic [6:0] route_pct = 7'h43;
  logic [6:0] func_pct = 7'h43;
  logic [6:0] drive_pct = 7'h43;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  wire logic [2:0] route_cmp, func_cmp, drive_cmp;
  wire logic amp_above, adapt_done;
  wire logic [5:0] cable_len;
  logic [7:0] reg_rdata_o;
  logic carrier_missing_n_o, adapt_run_o, eq_power_down_o, power_save_o, splitter_mode_o;
  logic driver_a_en_o, driver_b_en_o, bypass_o, mute_o;
  logic [2:0] swing_a_o, deemph_a_o, swing_b_o, deemph_b_o;
  int bad_count = 0;
  int n_compared = 0;

  sdieq_front_model #(.ADAPT_CYC(20)) model (.mclk_i(mclk_i), .rstn_i(rstn_i),
    .carrier_on_i(carrier_on), .length_i(length), .route_pct_i(route_pct),
    .func_pct_i(func_pct), .drive_pct_i(drive_pct), .route_cmp_o(route_cmp),
    .func_cmp_o(func_cmp), .drive_cmp_o(drive_cmp), .amp_above_o(amp_above),
    .adapt_done_o(adapt_done), .cable_len_o(cable_len));

  sdieq_ctrl uut (.mclk_i(mclk_i), .rstn_i(rstn_i), .route_cmp_i(route_cmp),
    .func_cmp_i(func_cmp), .drive_cmp_i(drive_cmp), .amp_above_i(amp_above),
    .adapt_done_i(adapt_done), .cable_len_i(cable_len), .reg_addr_i(reg_addr),
    .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata_o),
    .carrier_missing_n_o(carrier_missing_n_o), .adapt_run_o(adapt_run_o),
    .eq_power_down_o(eq_power_down_o), .power_save_o(power_save_o),
    .splitter_mode_o(splitter_mode_o), .driver_a_en_o(driver_a_en_o),
    .driver_b_en_o(driver_b_en_o), .bypass_o(bypass_o), .mute_o(mute_o),
    .swing_a_o(swing_a_o), .deemph_a_o(deemph_a_o), .swing_b_o(swing_b_o),
    .deemph_b_o(deemph_b_o));

  always #2 mclk_i = ~mclk_i;

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic cycles(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask : cycles

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk_i);
    reg_wr <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk_i);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk_i);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata_o;
  endtask : reg_read

  task automatic t_regs();
    logic [7:0] ofs[8] = '{OFS_MUTE_LIMIT, OFS_MODE_CTRL, OFS_PATH_CTRL, OFS_A_SWING,
      OFS_A_DEEMPH, OFS_B_SWING, OFS_B_DEEMPH, 8'h10};
    logic [7:0] rst[8] = '{8'h37, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] msk[8] = '{8'h3F, 8'h01, 8'h0F, 8'h27, 8'h47, 8'h27, 8'h47, 8'h00};
    logic [7:0] d;
    check("missing_n", 8'(carrier_missing_n_o), 8'h01);
    check("power_save", 8'(power_save_o), 8'h01);
    check("driver_a_en", 8'(driver_a_en_o), 8'h01);
    for (int i = 0; i < 8; i++) begin
      reg_read(ofs[i], d);
      check("reset value", d, rst[i]);
      reg_write(ofs[i], 8'hFF);
      reg_read(ofs[i], d);
      check("written bits", d, msk[i]);
      reg_write(ofs[i], rst[i]);
    end
    reg_write(OFS_CABLE_LEN, 8'hFF);
    reg_read(OFS_CABLE_LEN, d);
    check("read-only length", d, 8'h00);
    $display("test registers done");
  endtask : t_regs

  task automatic t_straps();
    logic [6:0] pct[4] = '{7'h00, 7'h21, 7'h43, 7'h64};
    logic [2:0] lvl[4] = '{DRV_LVL_L, DRV_LVL_R, DRV_LVL_F, DRV_LVL_H};
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk_i);
      route_pct <= pct[i];
      func_pct <= pct[i];
      drive_pct <= pct[i];
      cycles(6);
      check("swing_a", 8'(swing_a_o), 8'(lvl[i]));
      check("deemph_a", 8'(deemph_a_o), 8'(lvl[i]));
      check("swing_b", 8'(swing_b_o), 8'(lvl[i]));
      check("deemph_b", 8'(deemph_b_o), 8'(lvl[i]));
      check("driver_b_en", 8'(driver_b_en_o), 8'(i == 3));
      check("bypass", 8'(bypass_o), 8'(i == 3));
    end
    @(posedge mclk_i);
    route_pct <= 7'h43;
    func_pct <= 7'h43;
    drive_pct <= 7'h43;
    cycles(6);
    $display("test straps done");
  endtask : t_straps

  task automatic t_override();
    reg_write(OFS_PATH_CTRL, 8'h03);
    cycles(2);
    check("route override", 8'(driver_b_en_o), 8'h01);
    reg_write(OFS_PATH_CTRL, 8'h0C);
    cycles(2);
    check("func override", 8'(bypass_o), 8'h01);
    check("route strap back", 8'(driver_b_en_o), 8'h00);
    reg_write(OFS_PATH_CTRL, 8'h08);
    cycles(2);
    check("func strap back", 8'(bypass_o), 8'h00);
    reg_write(OFS_A_SWING, 8'h27);
    reg_write(OFS_B_DEEMPH, 8'h46);
    cycles(2);
    check("swing_a ovr", 8'(swing_a_o), 8'h07);
    check("swing_b strap", 8'(swing_b_o), 8'h02);
    check("deemph_b ovr", 8'(deemph_b_o), 8'h06);
    check("deemph_a strap", 8'(deemph_a_o), 8'h02);
    reg_write(OFS_A_SWING, 8'h07);
    reg_write(OFS_B_SWING, 8'h21);
    reg_write(OFS_A_DEEMPH, 8'h40);
    reg_write(OFS_B_DEEMPH, 8'h06);
    cycles(2);
    check("swing_a no ovr", 8'(swing_a_o), 8'h02);
    check("swing_b ovr", 8'(swing_b_o), 8'h01);
    check("deemph_a ovr", 8'(deemph_a_o), 8'h00);
    check("deemph_b no ovr", 8'(deemph_b_o), 8'h02);
    reg_write(OFS_PATH_CTRL, 8'h00);
    reg_write(OFS_B_SWING, 8'h00);
    reg_write(OFS_A_DEEMPH, 8'h00);
    reg_write(OFS_MODE_CTRL, 8'h01);
    cycles(2);
    check("splitter on", 8'(splitter_mode_o), 8'h01);
    reg_write(OFS_MODE_CTRL, 8'h00);
    cycles(2);
    check("splitter off", 8'(splitter_mode_o), 8'h00);
    $display("test overrides done");
  endtask : t_override

  task automatic t_carrier();
    int n;
    @(posedge mclk_i);
    carrier_on <= 1'b1;
    cycles(8);
    check("adapt_run", 8'(adapt_run_o), 8'h01);
    check("missing_n adapting", 8'(carrier_missing_n_o), 8'h01);
    check("power_save left", 8'(power_save_o), 8'h00);
    n = 0;
    while (carrier_missing_n_o !== 1'b0 && n < 40) begin
      cycles(1);
      n++;
    end
    check("missing_n locked", 8'(carrier_missing_n_o), 8'h00);
    check("eq powered", 8'(eq_power_down_o), 8'h00);
    @(posedge mclk_i);
    carrier_on <= 1'b0;
    cycles(6);
    check("missing_n lost", 8'(carrier_missing_n_o), 8'h01);
    check("eq power down", 8'(eq_power_down_o), 8'h01);
    check("power_save back", 8'(power_save_o), 8'h01);
    $display("test carrier done");
  endtask : t_carrier

  task automatic t_mute();
    logic [7:0] d;
    @(posedge mclk_i);
    length <= 6'h14;
    cycles(6);
    reg_read(OFS_CABLE_LEN, d);
    check("estimate", d, 8'h14);
    check("no mute default", 8'(mute_o), 8'h00);
    // Calibration copies the length reading into the threshold.
    reg_write(OFS_MUTE_LIMIT, d);
    @(posedge mclk_i);
    length <= 6'h15;
    cycles(6);
    check("mute above", 8'(mute_o), 8'h01);
    @(posedge mclk_i);
    length <= 6'h14;
    cycles(6);
    check("unmute at limit", 8'(mute_o), 8'h00);
    @(posedge mclk_i);
    length <= 6'h3F;
    cycles(6);
    reg_read(OFS_CABLE_LEN, d);
    check("estimate clamp", d, 8'(CABLE_LEN_MAX));
    check("mute long", 8'(mute_o), 8'h01);
    $display("test mute done");
  endtask : t_mute

  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_of_test

  initial begin
    repeat (10) @(posedge mclk_i);
    rstn_i <= 1'b1;
    cycles(6);
    t_regs();
    t_straps();
    t_override();
    t_carrier();
    t_mute();
    end_of_test();
  end

  initial begin
    #40000;
    bad_count++;
    end_of_test();
  end
endmodule : sdieq_ctrl_test
